// *** design/countdown_regs.sv ***
// Register block of the periodic countdown timer: preset and live value.
// Assumes the serial link front end decodes byte accesses into one-cycle
// read and write strobes on clk, with address and write data valid alongside.
//
// Summary of operation
// - Low preset byte writable, reset zero
// - High preset nibble bits 3:0, upper zero
// - Reload from preset at zero when repeating
// - Preset reads return preset, not counter
// - Preset writes ignored while protection active
// - Live low byte readable at 0Ch
// - Live high nibble at 0Dh, upper zero
// - Live registers read-only, writes discarded
// - Enabled low read captures high nibble shadow
// - High read returns captured shadow nibble
// - Disabling freezes both live registers
// - Period equals preset plus one over timer clock
`timescale 1ns/100ps
module countdown_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic write_protect,
  input wire logic countdown_run_enable,
  input wire logic repeat_reload_bit,
  input wire logic timer_tick,
  output logic countdown_expired
);
  logic [7:0] preset_low_reg;
  logic [7:0] preset_low_next;
  logic [3:0] preset_high_reg;
  logic [3:0] preset_high_next;
  logic [3:0] shadow_reg;
  logic [3:0] shadow_next;
  logic [11:0] live_reg;
  logic [11:0] live_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [11:0] count;
  logic wr_open;
  logic wr_preset_low;
  logic wr_preset_high;

  // Period is preset + 1 ticks of the timer clock (one tick reloads at zero); software picks the preset
  countdown_core #(
    .width(countdown_pkg::preset_width)
  ) core (
    .clk(clk),
    .rst(rst),
    .run(countdown_run_enable),
    .tick(timer_tick),
    .repeat_reload_bit(repeat_reload_bit),
    .preset({preset_high_reg, preset_low_reg}),
    .count(count),
    .expired(countdown_expired)
  );

  // Protection gates the strobe once, so both preset bytes see one decision
  assign wr_open = wr_stb && !write_protect;
  assign wr_preset_low = wr_open && (addr == countdown_pkg::preset_low_addr);
  assign wr_preset_high = wr_open && (addr == countdown_pkg::preset_high_addr);

  always_comb begin
    preset_low_next = preset_low_reg;
    preset_high_next = preset_high_reg;
    shadow_next = shadow_reg;
    live_next = live_reg;
    rdata_next = rdata_reg;
    // Live copy lags the counter by one cycle and stops with the enable bit
    if (countdown_run_enable) begin
      live_next = count;
    end
    if (wr_preset_low) begin
      preset_low_next = wdata;
    end
    if (wr_preset_high) begin
      preset_high_next = wdata[3:0];
    end
    // Live registers have no write path at all
    if (rd_stb) begin
      unique case (addr)
        countdown_pkg::preset_low_addr: rdata_next = preset_low_reg;
        countdown_pkg::preset_high_addr: rdata_next = {4'h0, preset_high_reg};
        countdown_pkg::live_low_addr: begin
          // Low byte and shadow come from one registered copy, so a pair whose low read is made while enabled never tears
          rdata_next = live_reg[7:0];
          if (countdown_run_enable) begin
            shadow_next = live_reg[11:8];
          end
        end
        countdown_pkg::live_high_addr: rdata_next = {4'h0, shadow_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      preset_low_reg <= countdown_pkg::preset_low_reset;
      preset_high_reg <= countdown_pkg::preset_high_reset;
      shadow_reg <= countdown_pkg::shadow_reset;
      live_reg <= countdown_pkg::counter_reset;
      rdata_reg <= 8'h00;
    end else begin
      preset_low_reg <= preset_low_next;
      preset_high_reg <= preset_high_next;
      shadow_reg <= shadow_next;
      live_reg <= live_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

  // Write side: protection, preset writes landing, live addresses dead
  a_protect_blocks: assert property (@(posedge clk) disable iff (rst)
    (wr_stb && write_protect) |=> $stable(preset_low_reg) && $stable(preset_high_reg))
    else $error("preset changed under protection");

  a_preset_low_wr: assert property (@(posedge clk) disable iff (rst)
    (wr_stb && !write_protect && addr == countdown_pkg::preset_low_addr)
      |=> preset_low_reg == $past(wdata))
    else $error("low preset not written");

  a_preset_high_wr: assert property (@(posedge clk) disable iff (rst)
    (wr_stb && !write_protect && addr == countdown_pkg::preset_high_addr)
      |=> preset_high_reg == $past(wdata[3:0]))
    else $error("high preset not written");

  a_live_wr_dead: assert property (@(posedge clk) disable iff (rst)
    (wr_stb && (addr == countdown_pkg::live_low_addr || addr == countdown_pkg::live_high_addr))
      |=> $stable(preset_low_reg) && $stable(preset_high_reg))
    else $error("live write reached preset");

  a_live_no_write: assert property (@(posedge clk) disable iff (rst)
    (wr_stb && !rd_stb && !countdown_run_enable) |=> $stable(live_reg) && $stable(shadow_reg))
    else $error("write changed live value");

  // Every register starts from zero once reset is released
  a_reset_zero: assert property (@(posedge clk)
    $fell(rst) |-> preset_low_reg == countdown_pkg::preset_low_reset
      && preset_high_reg == countdown_pkg::preset_high_reset && shadow_reg == countdown_pkg::shadow_reset
      && live_reg == countdown_pkg::counter_reset && rdata == 8'h00)
    else $error("register not zero after reset");

  // Read side: preset readback and upper bits that always read zero
  a_preset_readback: assert property (@(posedge clk) disable iff (rst)
    (rd_stb && addr == countdown_pkg::preset_low_addr) |=> rdata == $past(preset_low_reg))
    else $error("preset read wrong");

  a_preset_high_read: assert property (@(posedge clk) disable iff (rst)
    (rd_stb && addr == countdown_pkg::preset_high_addr) |=> rdata == {4'h0, $past(preset_high_reg)})
    else $error("high preset read wrong");

  a_high_upper_zero: assert property (@(posedge clk) disable iff (rst)
    (rd_stb && (addr == countdown_pkg::preset_high_addr || addr == countdown_pkg::live_high_addr))
      |=> rdata[7:4] == 4'h0)
    else $error("upper nibble not zero");

  // Live copy follows the counter one cycle late and stops with the enable
  a_live_tracks: assert property (@(posedge clk) disable iff (rst)
    countdown_run_enable |=> live_reg == $past(count))
    else $error("live copy not tracking counter");

  a_live_low_read: assert property (@(posedge clk) disable iff (rst)
    (rd_stb && addr == countdown_pkg::live_low_addr) |=> rdata == $past(live_reg[7:0]))
    else $error("live low read wrong");

  a_live_hold_off: assert property (@(posedge clk) disable iff (rst)
    !countdown_run_enable |=> $stable(live_reg))
    else $error("live copy moved after disable");

  a_freeze_live: assert property (@(posedge clk) disable iff (rst)
    (!countdown_run_enable ##1 !countdown_run_enable) |-> $stable(live_reg) && $stable(shadow_reg))
    else $error("live value moved while disabled");

  a_freeze_shadow: assert property (@(posedge clk) disable iff (rst)
    !countdown_run_enable |=> $stable(shadow_reg))
    else $error("shadow moved while disabled");

  // A capture and the high read that uses it; a low read in between would
  // recapture, so the pair check only looks at undisturbed pairs
  sequence s_low_capture;
    rd_stb && countdown_run_enable && addr == countdown_pkg::live_low_addr;
  endsequence

  sequence s_no_low_read;
    !(rd_stb && addr == countdown_pkg::live_low_addr);
  endsequence

  sequence s_high_read;
    rd_stb && addr == countdown_pkg::live_high_addr;
  endsequence

  a_shadow_capture: assert property (@(posedge clk) disable iff (rst)
    s_low_capture |=> shadow_reg == $past(live_reg[11:8]))
    else $error("shadow not captured");

  a_shadow_kept: assert property (@(posedge clk) disable iff (rst)
    (rd_stb && !countdown_run_enable && addr == countdown_pkg::live_low_addr)
      |=> $stable(shadow_reg))
    else $error("shadow captured while disabled");

  a_shadow_read: assert property (@(posedge clk) disable iff (rst)
    s_high_read |=> rdata[3:0] == $past(shadow_reg))
    else $error("high read not shadow");

  a_pair_consistent: assert property (@(posedge clk) disable iff (rst)
    s_low_capture ##1 s_no_low_read[*2] ##1 s_high_read |=> rdata[3:0] == $past(live_reg[11:8], 4))
    else $error("high read not paired with low read");

  // Expiry pulse rises on the same edge as the last decrement, one edge after a tick seen at count 1
  a_expired_pulse: assert property (@(posedge clk) disable iff (rst)
    (countdown_run_enable && timer_tick && count == 12'h001) |=> countdown_expired)
    else $error("expiry pulse missing");

  a_expired_quiet: assert property (@(posedge clk) disable iff (rst)
    !(countdown_run_enable && timer_tick && count == 12'h001) |=> !countdown_expired)
    else $error("stray expiry pulse");
endmodule

// *** design/countdown_pkg.sv ***
// Constants for the periodic countdown timer register block.
// Assumes an 8-bit register port with byte addresses as printed.
package countdown_pkg;
  localparam logic [7:0] preset_low_addr = 8'h0a;
  localparam logic [7:0] preset_high_addr = 8'h0b;
  localparam logic [7:0] live_low_addr = 8'h0c;
  localparam logic [7:0] live_high_addr = 8'h0d;
  localparam int preset_width = 12;
  localparam int low_width = 8;
  localparam int high_width = 4;
  localparam logic [7:0] preset_low_reset = 8'h00;
  localparam logic [3:0] preset_high_reset = 4'h0;
  localparam logic [11:0] counter_reset = 12'h000;
  localparam logic [3:0] shadow_reset = 4'h0;
endpackage

// *** design/countdown_core.sv ***
// Twelve-bit down counter with optional reload from the preset.
// Assumes tick is a one-cycle pulse on clk from the selected timer clock.
`timescale 1ns/100ps
module countdown_core #(
  parameter int width = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic tick,
  input wire logic repeat_reload_bit,
  input wire logic [width-1:0] preset,
  output logic [width-1:0] count,
  output logic expired
);
  logic [width-1:0] count_reg;
  logic [width-1:0] count_next;
  logic expired_reg;
  logic expired_next;

  always_comb begin
    count_next = count_reg;
    expired_next = 1'b0;
    if (run && tick) begin
      if (count_reg == '0) begin
        if (repeat_reload_bit) begin
          count_next = preset;
        end
      end else begin
        count_next = count_reg - 1'b1;
        expired_next = (count_reg == width'(1));
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
      expired_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      expired_reg <= expired_next;
    end
  end

  assign count = count_reg;
  assign expired = expired_reg;

  a_stop_at_zero: assert property (@(posedge clk) disable iff (rst)
    (run && tick && count_reg == '0 && !repeat_reload_bit) |=> count_reg == '0)
    else $error("counter left zero without reload");
  a_reload_preset: assert property (@(posedge clk) disable iff (rst)
    (run && tick && count_reg == '0 && repeat_reload_bit) |=> count_reg == $past(preset))
    else $error("counter did not reload preset");
  a_count_decrement: assert property (@(posedge clk) disable iff (rst)
    (run && tick && count_reg != '0) |=> count_reg == $past(count_reg) - 1'b1)
    else $error("counter did not decrement");
endmodule

// *** bench/host_model.sv ***
// Host side model: register byte accesses and timer clock ticks.
// Assumes the block samples strobes and tick on the rising edge of clk.
`timescale 1ns/100ps
module host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr_stb,
  output logic rd_stb,
  output logic timer_tick
);
  initial {addr, wdata, wr_stb, rd_stb, timer_tick} = '0;
  // Idle bus lines show the inverse so nothing stale looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    addr <= ~a;
    // Read data stands until the next read, so take it one edge later
    @(posedge clk);
    d = rdata;
  endtask
  // One timer clock period; software scales the preset to this rate
  task automatic tick();
    @(posedge clk);
    timer_tick <= 1'b1;
    @(posedge clk);
    timer_tick <= 1'b0;
  endtask
endmodule

// *** bench/test_countdown_regs.sv ***
// Self-checking bench of the countdown register block.
// Assumes host_model drives the register port and ticks.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module test_countdown_regs;
  logic clk, rst, write_protect, countdown_run_enable, repeat_reload_bit;
  logic countdown_expired, wr_stb, rd_stb, timer_tick;
  logic [7:0] addr, wdata, rdata, v;
  int err_count = 0;
  int n_compared = 0;
  int n_expired = 0;
  countdown_regs i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .write_protect(write_protect),
    .countdown_run_enable(countdown_run_enable), .repeat_reload_bit(repeat_reload_bit),
    .timer_tick(timer_tick), .countdown_expired(countdown_expired));
  host_model i_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .timer_tick(timer_tick));
  always @(negedge clk) if (countdown_expired === 1'b1) n_expired++;
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, v);
    `CHK($sformatf("reg %h", a), e, v)
  endtask
  task automatic t_reset();
    chk(8'h0a, 8'h00);
    chk(8'h0b, 8'h00);
    chk(8'h0c, 8'h00);
    chk(8'h0d, 8'h00);
  endtask
  task automatic t_preset();
    i_host.wr(8'h0a, 8'h01);
    i_host.wr(8'h0b, 8'hf1);
    chk(8'h0a, 8'h01);
    chk(8'h0b, 8'h01);
    write_protect <= 1'b1;
    i_host.wr(8'h0a, 8'hff);
    i_host.wr(8'h0b, 8'h0e);
    chk(8'h0a, 8'h01);
    chk(8'h0b, 8'h01);
    write_protect <= 1'b0;
    i_host.wr(8'h0c, 8'haa);
    i_host.wr(8'h0d, 8'h0a);
    chk(8'h0c, 8'h00);
    chk(8'h0d, 8'h00);
  endtask
  task automatic t_live();
    countdown_run_enable <= 1'b1;
    repeat_reload_bit <= 1'b1;
    repeat (2) i_host.tick();
    chk(8'h0c, 8'h00);
    i_host.tick();
    chk(8'h0b, 8'h01);
    chk(8'h0d, 8'h01);
    chk(8'h0c, 8'hff);
    chk(8'h0d, 8'h00);
  endtask
  task automatic t_freeze();
    countdown_run_enable <= 1'b0;
    repeat (3) i_host.tick();
    chk(8'h0c, 8'hff);
    chk(8'h0d, 8'h00);
  endtask
  task automatic t_wrap();
    countdown_run_enable <= 1'b1;
    repeat (255) i_host.tick();
    @(posedge clk);
    `CHK("expired", 1, n_expired)
    repeat_reload_bit <= 1'b0;
    i_host.tick();
    chk(8'h0c, 8'h00);
    repeat_reload_bit <= 1'b1;
    i_host.tick();
    chk(8'h0c, 8'h01);
    chk(8'h0d, 8'h01);
  endtask
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(50 * 5000);
    err_count++;
    wrap_up();
  end
  initial begin
    {rst, write_protect, countdown_run_enable, repeat_reload_bit} = 4'h8;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_preset();
    t_live();
    t_freeze();
    t_wrap();
    wrap_up();
  end
endmodule
